/* File: logic/wss_wiper_unit.v */
// Three-channel wiper step and shift unit with address straps
//
// Contract
// - Step command raises or lowers one or all wipers by one.
// - Plus 6 dB shifts the wiper code one place left.
// - Minus 6 dB shifts the code right, dropping the low bit.
// - Shift commands have single and all-channel forms; all update together.
// - Left shift of zero loads code one.
// - Left shift at or above midscale loads full scale and stays.
// - Right shift truncates odd codes and settles at zero.
// - Two select pins set the user memory bus address.
// - Undriven write-protect counts as protected and blocks memory writes.
// - Two address select pins form part of the slave address.
// - Two 512-position channels and one 128-position channel, codes in range.
// - Code decodes one-hot to a tap; bottom switch always on.
// - Wide channels use nine-bit codes selecting one of 512 taps.
// - No acknowledge while a command runs; master polls until answered.
`timescale 1ns/1ns
`default_nettype none
module wss_wiper_unit (
  input wire core_clk,
  input wire reset,
  input wire commandValid,
  input wire [3:0] command,
  input wire [1:0] channelSel,
  input wire writeValid,
  input wire [1:0] writeChannel,
  input wire [8:0] writeCode,
  input wire user_mem_addr_sel_hi,
  input wire user_mem_addr_sel_lo,
  input wire bus_addr_sel_hi,
  input wire bus_addr_sel_lo,
  input wire writeProtectDriven,
  input wire writeProtectLevel,
  input wire memWriteRequest,
  output wire busy,
  output wire ackEnable,
  output reg [6:0] slaveAddress,
  output reg [6:0] userMemAddress,
  output reg memWriteAllowed,
  output wire [8:0] wiper0,
  output wire [8:0] wiper1,
  output wire [6:0] wiper2,
  output wire [511:0] tap0,
  output wire [511:0] tap1,
  output wire [127:0] tap2,
  output wire bottom_terminal_switch
);
`include "wss_regs.vh"
  reg [1:0] busyCount;
  reg [3:0] pinSync0;
  reg [3:0] pinSync1;
  reg [3:0] pinSync2;
  reg [3:0] pinStable;
  reg [1:0] wpSync0;
  reg [1:0] wpSync1;
  reg [1:0] wpSync2;
  reg [1:0] wpStable;
  wire isAll;
  wire take;
  wire [2:0] applyCh;
  wire [2:0] loadCh;

  ////////////////////////////////////////////////////////////////
  // Strap and write-protect pins pass three flops; a change counts
  // only once the second and third stages agree
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinSync0 <= 4'h0;
      pinSync1 <= 4'h0;
      pinSync2 <= 4'h0;
      pinStable <= 4'h0;
      wpSync0 <= 2'h0;
      wpSync1 <= 2'h0;
      wpSync2 <= 2'h0;
      wpStable <= 2'h0;
    end else begin
      pinSync0 <= {user_mem_addr_sel_hi, user_mem_addr_sel_lo, bus_addr_sel_hi, bus_addr_sel_lo};
      pinSync1 <= pinSync0;
      pinSync2 <= pinSync1;
      if (pinSync1 == pinSync2)
        pinStable <= pinSync2;
      wpSync0 <= {writeProtectDriven, writeProtectLevel};
      wpSync1 <= wpSync0;
      wpSync2 <= wpSync1;
      if (wpSync1 == wpSync2)
        wpStable <= wpSync2;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Addresses and write permission, all registered
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Fixed bases show from reset on, straps read as zero until synced
      slaveAddress <= {`WSS_SLAVE_ADDR_BASE, 2'h0};
      userMemAddress <= {`WSS_MEM_ADDR_BASE, 2'h0};
      memWriteAllowed <= 1'b0;
    end else begin
      slaveAddress <= {`WSS_SLAVE_ADDR_BASE, pinStable[1:0]};
      userMemAddress <= {`WSS_MEM_ADDR_BASE, pinStable[3:2]};
      // floating means protected
      // Protection is active low; an undriven pin reads as protected
      memWriteAllowed <= memWriteRequest & wpStable[1] & wpStable[0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Busy window: commands arriving while busy are ignored
  // no ack while busy
  assign take = commandValid & (busyCount == 2'h0);
  assign busy = (busyCount != 2'h0);
  assign ackEnable = ~busy;
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      busyCount <= 2'h0;
    else if (take && command != `WSS_CMD_NOP)
      busyCount <= `WSS_BUSY_CYCLES;
    else if (busyCount != 2'h0)
      busyCount <= busyCount - 2'h1;
  end

  assign isAll = (command == `WSS_CMD_DEC_ALL_6DB) | (command == `WSS_CMD_INC_ALL_6DB) |
                 (command == `WSS_CMD_DEC_ALL_STEP) | (command == `WSS_CMD_INC_ALL_STEP);
  // Channel 3 selects nothing, so single commands to it are dropped
  assign applyCh[0] = take & (isAll | (channelSel == 2'h0));
  assign applyCh[1] = take & (isAll | (channelSel == 2'h1));
  assign applyCh[2] = take & (isAll | (channelSel == 2'h2));
  // Direct writes lose to nothing; they only land while idle
  assign loadCh[0] = writeValid & ~busy & (writeChannel == 2'h0);
  assign loadCh[1] = writeValid & ~busy & (writeChannel == 2'h1);
  assign loadCh[2] = writeValid & ~busy & (writeChannel == 2'h2);

  ////////////////////////////////////////////////////////////////
  // two wide one narrow
  wss_channel #(.WIDTH(`WSS_WIDE_BITS), .RESET_CODE(`WSS_WIDE_RESET)) wideCh0 (
    .core_clk(core_clk),
    .reset(reset),
    .apply(applyCh[0]),
    .command(command),
    .load(loadCh[0]),
    .loadCode(writeCode),
    .wiperRegister(wiper0),
    .tapSwitch(tap0)
  );
  wss_channel #(.WIDTH(`WSS_WIDE_BITS), .RESET_CODE(`WSS_WIDE_RESET)) wideCh1 (
    .core_clk(core_clk),
    .reset(reset),
    .apply(applyCh[1]),
    .command(command),
    .load(loadCh[1]),
    .loadCode(writeCode),
    .wiperRegister(wiper1),
    .tapSwitch(tap1)
  );
  wss_channel #(.WIDTH(`WSS_NARROW_BITS), .RESET_CODE(`WSS_NARROW_RESET)) narrowCh2 (
    .core_clk(core_clk),
    .reset(reset),
    .apply(applyCh[2]),
    .command(command),
    .load(loadCh[2]),
    .loadCode(writeCode[6:0]),
    .wiperRegister(wiper2),
    .tapSwitch(tap2)
  );

  assign bottom_terminal_switch = 1'b1;
endmodule
`default_nettype wire

/* File: logic/wss_regs.vh */
// Constants for the wiper step and shift unit
`ifndef WSS_REGS_VH
`define WSS_REGS_VH
// Command codes on the shortcut command port
`define WSS_CMD_NOP 4'h0
`define WSS_CMD_DEC_6DB 4'h3
`define WSS_CMD_DEC_ALL_6DB 4'h4
`define WSS_CMD_DEC_STEP 4'h5
`define WSS_CMD_DEC_ALL_STEP 4'h6
`define WSS_CMD_INC_6DB 4'h8
`define WSS_CMD_INC_ALL_6DB 4'h9
`define WSS_CMD_INC_STEP 4'hA
`define WSS_CMD_INC_ALL_STEP 4'hB
// Wiper widths and reset codes
`define WSS_WIDE_BITS 9
`define WSS_NARROW_BITS 7
`define WSS_WIDE_RESET 9'h100
`define WSS_NARROW_RESET 7'h40
// Fixed high part of the serial slave address
`define WSS_SLAVE_ADDR_BASE 5'h0A
// Fixed high part of the user memory address
`define WSS_MEM_ADDR_BASE 5'h14
// Cycles the bus stays unacknowledged while a command runs
`define WSS_BUSY_CYCLES 2'h2
`endif

/* File: logic/wss_channel.v */
// One wiper channel: register, step, shift and tap decode
`timescale 1ns/1ns
`default_nettype none
module wss_channel #(
  parameter integer WIDTH = 9,
  parameter [WIDTH-1:0] RESET_CODE = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire reset,
  input wire apply,
  input wire [3:0] command,
  input wire load,
  input wire [WIDTH-1:0] loadCode,
  output reg [WIDTH-1:0] wiperRegister,
  output reg [(1<<WIDTH)-1:0] tapSwitch
);
`include "wss_regs.vh"
  localparam [WIDTH-1:0] FULL = {WIDTH{1'b1}};
  localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
  reg [WIDTH-1:0] next_wiperRegister;

  ////////////////////////////////////////////////////////////////
  // Next wiper code; every arithmetic path saturates in range
  always @* begin
    next_wiperRegister = wiperRegister;
    if (load) begin
      next_wiperRegister = loadCode;
    end else if (apply) begin
      case (command)
        `WSS_CMD_INC_STEP, `WSS_CMD_INC_ALL_STEP: begin
          if (wiperRegister != FULL)
            next_wiperRegister = wiperRegister + ONE;
        end
        `WSS_CMD_DEC_STEP, `WSS_CMD_DEC_ALL_STEP: begin
          if (wiperRegister != {WIDTH{1'b0}})
            next_wiperRegister = wiperRegister - ONE;
        end
        `WSS_CMD_INC_6DB, `WSS_CMD_INC_ALL_6DB: begin
          if (wiperRegister == {WIDTH{1'b0}})
            next_wiperRegister = ONE;
          else if (wiperRegister[WIDTH-1])
            next_wiperRegister = FULL;
          else
            next_wiperRegister = {wiperRegister[WIDTH-2:0], 1'b0};
        end
        `WSS_CMD_DEC_6DB, `WSS_CMD_DEC_ALL_6DB: begin
          next_wiperRegister = {1'b0, wiperRegister[WIDTH-1:1]};
        end
        default: begin
          next_wiperRegister = wiperRegister;
        end
      endcase
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wiperRegister <= RESET_CODE;
      // Tap follows the reset code so the decode is never out of step
      tapSwitch <= {{((1<<WIDTH)-1){1'b0}}, 1'b1} << RESET_CODE;
    end else begin
      wiperRegister <= next_wiperRegister;
      tapSwitch <= {{((1<<WIDTH)-1){1'b0}}, 1'b1} << next_wiperRegister;
    end
  end
endmodule
`default_nettype wire

/* File: dv/wss_wiper_unit_properties.sv */
// Port assertions for the wiper step and shift unit
`timescale 1ns/1ns
`default_nettype none
module wss_wiper_unit_properties (
  input wire core_clk,
  input wire reset,
  input wire commandValid,
  input wire [3:0] command,
  input wire writeValid,
  input wire busy,
  input wire ackEnable,
  input wire [6:0] slaveAddress,
  input wire [6:0] userMemAddress,
  input wire [8:0] wiper0,
  input wire [8:0] wiper1,
  input wire [6:0] wiper2,
  input wire [511:0] tap0,
  input wire [511:0] tap1,
  input wire [127:0] tap2,
  input wire bottom_terminal_switch
);
  // Taken command; a write on the same edge would mask the shift
  wire take = commandValid && !busy && !writeValid;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Two busy cycles, then acknowledge again
  sequence busyRun;
    busy [*2] ##1 !busy;
  endsequence
  ack_is_free_a: assert property (ackEnable == !busy)
    else $error("ack not inverse of busy");
  busy_window_a:
    assert property (take && command inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB}
      |=> busyRun) else $error("busy window wrong");
  hold_busy_a:
    assert property (busy |=> $stable(wiper0) && $stable(wiper1) && $stable(wiper2))
      else $error("wiper moved while busy");
  tap_onehot_a:
    assert property (tap0 == (512'h1 << wiper0)) else $error("tap decode");
  tap_others_a:
    assert property (tap1 == (512'h1 << wiper1) && tap2 == (128'h1 << wiper2))
      else $error("tap decode on other channels");
  bottom_on_a: assert property (bottom_terminal_switch)
    else $error("bottom switch off");
  step_up_a:
    assert property (take && command == 4'hB && wiper2 != 7'h7F |=> wiper2 == $past(wiper2) + 7'h01)
      else $error("step up wrong");
  zero_left_a:
    assert property (take && command == 4'h9 && wiper0 == 9'h000 |=> wiper0 == 9'h001)
      else $error("zero left shift");
  full_left_a:
    assert property (take && command == 4'h9 && wiper1[8] |=> wiper1 == 9'h1FF)
      else $error("saturating left shift");
  right_all_a:
    assert property (take && command == 4'h4 |=> wiper0 == $past(wiper0) >> 1
      && wiper1 == $past(wiper1) >> 1 && wiper2 == $past(wiper2) >> 1) else $error("right shift");
  addr_base_a:
    assert property (slaveAddress[6:2] == 5'h0A && userMemAddress[6:2] == 5'h14)
      else $error("address base");
endmodule
bind wss_wiper_unit wss_wiper_unit_properties wss_wiper_unit_properties_i (.core_clk, .reset,
  .commandValid, .command, .writeValid, .busy, .ackEnable, .slaveAddress, .userMemAddress,
  .wiper0, .wiper1, .wiper2, .tap0, .tap1, .tap2, .bottom_terminal_switch);
`default_nettype wire

/* File: dv/wss_bus_master.sv */
// Bus master model: commands and wiper writes with acknowledge polling
`timescale 1ns/1ns
`default_nettype none
module wss_bus_master (
  input wire core_clk,
  input wire ackEnable,
  output logic commandValid = 1'b0,
  output logic [3:0] command = 4'h0,
  output logic [1:0] channelSel = 2'h0,
  output logic writeValid = 1'b0,
  output logic [1:0] writeChannel = 2'h0,
  output logic [8:0] writeCode = 9'h000
);
  int polls;
  // acknowledge polling
  // With poll low the request barges in while the device is busy
  task automatic send(input logic isWr, input logic [3:0] c, input logic [1:0] ch,
                      input logic [8:0] code, input logic poll);
    polls = 0;
    while (poll && ackEnable !== 1'b1 && polls < 20) begin
      @(posedge core_clk);
      #1;
      polls++;
    end
    commandValid = !isWr;
    writeValid = isWr;
    command = c;
    channelSel = ch;
    writeChannel = ch;
    writeCode = code;
    @(posedge core_clk);
    #1;
    commandValid = 1'b0;
    writeValid = 1'b0;
    // Released lines change so stale values cannot pass
    command = ~c;
    writeCode = ~code;
    channelSel = ~ch;
    writeChannel = ~ch;
    // Let an edge pass so a following call never raises a strobe in the same step
    @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/wss_wiper_unit_bench.sv */
// Self-checking bench for the wiper step and shift unit
`timescale 1ns/1ns
`default_nettype none
module wss_wiper_unit_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] busSel = 2'h0;
  logic [1:0] memSel = 2'h0;
  logic wpDriven = 1'b0;
  logic wpLevel = 1'b0;
  logic memWriteRequest = 1'b0;
  logic [8:0] exp;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  wire commandValid, writeValid, busy, ackEnable, memWriteAllowed, bottom_terminal_switch;
  wire [3:0] command;
  wire [1:0] channelSel, writeChannel;
  wire [8:0] writeCode, wiper0, wiper1;
  wire [6:0] wiper2, slaveAddress, userMemAddress;
  wire [511:0] tap0, tap1;
  wire [127:0] tap2;
  wss_wiper_unit wss_wiper_unit_i (.core_clk, .reset, .commandValid, .command, .channelSel,
    .writeValid, .writeChannel, .writeCode, .user_mem_addr_sel_hi(memSel[1]),
    .user_mem_addr_sel_lo(memSel[0]), .bus_addr_sel_hi(busSel[1]), .bus_addr_sel_lo(busSel[0]),
    .writeProtectDriven(wpDriven), .writeProtectLevel(wpLevel), .memWriteRequest, .busy,
    .ackEnable, .slaveAddress, .userMemAddress, .memWriteAllowed, .wiper0, .wiper1, .wiper2,
    .tap0, .tap1, .tap2, .bottom_terminal_switch);
  wss_bus_master wss_bus_master_i (.core_clk, .ackEnable, .commandValid, .command,
    .channelSel, .writeValid, .writeChannel, .writeCode);
  // Clock and a hang guard well past the expected run of under two hundred cycles
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end
  //////////////////////////////////////////////////
  task automatic chkCode(input logic [8:0] got, input logic [8:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, want);
    end
  endtask
  task automatic chkAll(input logic [8:0] a, input logic [8:0] b, input logic [6:0] c);
    chkCode(wiper0, a);
    chkCode(wiper1, b);
    chkCode({2'h0, wiper2}, {2'h0, c});
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] ch);
    wss_bus_master_i.send(1'b0, c, ch, 9'h000, 1'b1);
  endtask
  task automatic wr(input logic [1:0] ch, input logic [8:0] code);
    wss_bus_master_i.send(1'b1, 4'h0, ch, code, 1'b1);
  endtask
  task final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    chkAll(9'h100, 9'h100, 7'h40);
    // Left shifts from zero, through midscale into saturation
    wr(2'h0, 9'h000);
    exp = 9'h001;
    for (i = 0; i < 11; i++) begin
      cmd(4'h8, 2'h0);
      chkCode(wiper0, exp);
      exp = exp[8] ? 9'h1FF : exp << 1;
    end
    // Right shifts from full scale settle at zero
    wr(2'h1, 9'h1FF);
    exp = 9'h1FF;
    for (i = 0; i < 10; i++) begin
      exp = exp >> 1;
      cmd(4'h3, 2'h1);
      chkCode(wiper1, exp);
    end
    wr(2'h0, 9'h001);
    wr(2'h1, 9'h101);
    wr(2'h2, 9'h041);
    cmd(4'h4, 2'h3);
    chkAll(9'h000, 9'h080, 7'h20);
    cmd(4'h9, 2'h3);
    chkAll(9'h001, 9'h100, 7'h40);
    cmd(4'h9, 2'h3);
    chkAll(9'h002, 9'h1FF, 7'h7F);
    cmd(4'hB, 2'h3);
    chkAll(9'h003, 9'h1FF, 7'h7F);
    cmd(4'hA, 2'h0);
    chkAll(9'h004, 9'h1FF, 7'h7F);
    cmd(4'h5, 2'h1);
    chkAll(9'h004, 9'h1FE, 7'h7F);
    wr(2'h2, 9'h000);
    cmd(4'h6, 2'h3);
    chkAll(9'h003, 9'h1FD, 7'h00);
    // A command barging in during busy is dropped
    cmd(4'hA, 2'h1);
    chkCode({8'h00, ackEnable}, 9'h000);
    wss_bus_master_i.send(1'b0, 4'hA, 2'h1, 9'h000, 1'b0);
    chkCode(wiper1, 9'h1FE);
    chkCode({8'h00, ackEnable}, 9'h001);
    // Strap pins reach both addresses after the synchroniser
    for (i = 0; i < 4; i++) begin
      busSel = i[1:0];
      memSel = ~i[1:0];
      repeat (8) @(posedge core_clk);
      #1;
      chkCode({2'h0, slaveAddress}, {2'h0, 5'h0A, busSel});
      chkCode({2'h0, userMemAddress}, {2'h0, 5'h14, memSel});
    end
    // Undriven, driven high, driven low write protect
    memWriteRequest = 1'b1;
    for (i = 0; i < 3; i++) begin
      {wpDriven, wpLevel} = (i == 0) ? 2'b01 : (i == 1) ? 2'b11 : 2'b10;
      repeat (8) @(posedge core_clk);
      #1;
      chkCode({8'h00, memWriteAllowed}, {8'h00, i == 1});
    end
    final_report();
  end
endmodule
`default_nettype wire
